// file: swm_defines.vh
// swm_defines.vh: offsets, field positions, reset values and timing counts
// assumes: included by the warning manager files, 100 MHz pclk
`ifndef SWM_DEFINES_VH
`define SWM_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SWM_OFF_SEL1        12'h000
`define SWM_OFF_SEL2        12'h004
`define SWM_OFF_MASK        12'h008
`define SWM_OFF_STATUS      12'h00C
`define SWM_OFF_IRQ_MASK    12'h010
`define SWM_OFF_LIMITS      12'h014
`define SWM_OFF_LIFE_LIM    12'h018
`define SWM_OFF_CTRL        12'h01C

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SWM_RST_SEL         16'h0000
`define SWM_RST_MASK        16'h0000
`define SWM_RST_IRQ_MASK    16'h0000
`define SWM_RST_ENC_LIM     8'h08
`define SWM_RST_EXT_LIM     8'h08
`define SWM_RST_LIFE_LIM    16'h0100

// ----------------------------------------------------------------
// mask bit positions
// ----------------------------------------------------------------
`define SWM_BIT_BATTERY     0
`define SWM_BIT_LIFE        2
`define SWM_BIT_ENC_HOT     3
`define SWM_BIT_ENC_COMM    4
`define SWM_BIT_REGEN       5
`define SWM_BIT_FAN         6
`define SWM_BIT_OVERLOAD    7
`define SWM_BIT_EXT_ENC     8
`define SWM_BIT_VIBRATION   9
`define SWM_BIT_EXT_COMM    10

// ----------------------------------------------------------------
// selection codes
// ----------------------------------------------------------------
`define SWM_SEL_ALL         16'h0000
`define SWM_SEL_OVERLOAD    16'h0001
`define SWM_SEL_REGEN       16'h0002
`define SWM_SEL_BATTERY     16'h0003
`define SWM_SEL_FAN         16'h0004
`define SWM_SEL_ENC_COMM    16'h0005
`define SWM_SEL_ENC_HOT     16'h0006
`define SWM_SEL_VIBRATION   16'h0007
`define SWM_SEL_LIFE        16'h0008
`define SWM_SEL_EXT_ENC     16'h0009
`define SWM_SEL_EXT_COMM    16'h000A

// ----------------------------------------------------------------
// thresholds and timing
// ----------------------------------------------------------------
`define SWM_LOAD_PCT        85
`define SWM_BATT_MV         3200
`define SWM_BATT_LIM        16'h0C80
`define SWM_FAN_MS          1000
`define SWM_CLK_MHZ         100
`define SWM_FAN_CYCLES      (`SWM_FAN_MS * 1000 * `SWM_CLK_MHZ)
`define SWM_CTRL_RESET_BIT  0

`endif

// file: swm_err_counter.v
// swm_err_counter.v: consecutive error counter with limit compare
// assumes: one pulse per communication attempt, synchronous to pclk
`timescale 1ns/1ps
module swm_err_counter (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       attempt,
	input  wire       error,
	input  wire [7:0] limit,
	output wire       over
);
	reg  [7:0] count_ff;
	reg  [7:0] nxt_count;

	always @* begin
		nxt_count = count_ff;
		if (attempt) begin
			if (!error)
				nxt_count = 8'h00;
			else if (count_ff != 8'hFF)
				nxt_count = count_ff + 8'h01;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			count_ff <= 8'h00;
		else
			count_ff <= nxt_count;
	end

	assign over = (count_ff > limit);
endmodule // swm_err_counter

// file: swm_warning_manager.v
// swm_warning_manager.v: servo warning latch, mask, routing and apb registers
// assumes: detection inputs synchronous to pclk, apb master on pclk
`timescale 1ns/1ps
`include "swm_defines.vh"
module swm_warning_manager #(
	parameter FAN_CYCLES = `SWM_FAN_CYCLES
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire [6:0]  load_ratio_pct,
	input  wire [6:0]  regen_ratio_pct,
	input  wire [15:0] battery_mv,
	input  wire        fan_stopped,
	input  wire        enc_attempt,
	input  wire        enc_error,
	input  wire        enc_overheat,
	input  wire        vibration_detected,
	input  wire [15:0] capacitor_life,
	input  wire [15:0] fan_life,
	input  wire        ext_enc_warning,
	input  wire        ext_attempt,
	input  wire        ext_error,
	input  wire        alarm_reset,
	output wire        warning_output_one,
	output wire        warning_output_two,
	output wire        irq
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg  [15:0] warning_route_select_one_ff;
	reg  [15:0] warning_route_select_two_ff;
	reg  [15:0] warning_detect_mask_ff;
	reg  [10:0] irq_mask_ff;
	reg  [7:0]  enc_limit_ff;
	reg  [7:0]  ext_limit_ff;
	reg  [15:0] life_limit_ff;
	reg  [10:0] latched_ff;
	reg  [10:0] irq_status_ff;
	reg  [31:0] fan_count_ff;
	reg  [31:0] nxt_fan_count;
	reg  [10:0] nxt_latched;
	reg  [10:0] nxt_irq_status;
	reg  [31:0] nxt_prdata;

	wire        wr_en;
	wire        rd_en;
	wire        addr_hit;
	wire        ctrl_clear;
	wire        clear_all;
	wire        enc_over;
	wire        ext_over;
	wire [10:0] detect;
	wire [10:0] set_evt;
	wire [10:0] route_one;
	wire [10:0] route_two;
	wire [10:0] unmasked;

	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign addr_hit = (paddr == `SWM_OFF_SEL1) || (paddr == `SWM_OFF_SEL2) ||
		(paddr == `SWM_OFF_MASK) || (paddr == `SWM_OFF_STATUS) ||
		(paddr == `SWM_OFF_IRQ_MASK) || (paddr == `SWM_OFF_LIMITS) ||
		(paddr == `SWM_OFF_LIFE_LIM) || (paddr == `SWM_OFF_CTRL);
	assign pslverr = psel & penable & ~addr_hit;

	// ----------------------------------------------------------------
	// warning detection
	// ----------------------------------------------------------------
	swm_err_counter u_enc_cnt (
		.pclk    (pclk),
		.presetn (presetn),
		.attempt (enc_attempt),
		.error   (enc_error),
		.limit   (enc_limit_ff),
		.over    (enc_over)
	);

	swm_err_counter u_ext_cnt (
		.pclk    (pclk),
		.presetn (presetn),
		.attempt (ext_attempt),
		.error   (ext_error),
		.limit   (ext_limit_ff),
		.over    (ext_over)
	);

	// fan stop duration counter
	always @* begin
		nxt_fan_count = fan_count_ff;
		if (!fan_stopped)
			nxt_fan_count = 32'h00000000;
		else if (fan_count_ff < FAN_CYCLES)
			nxt_fan_count = fan_count_ff + 32'h00000001;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fan_count_ff <= 32'h00000000;
		else
			fan_count_ff <= nxt_fan_count;
	end

	assign detect[`SWM_BIT_BATTERY]   = (battery_mv <= `SWM_BATT_LIM);
	assign detect[1]                  = 1'b0;
	assign detect[`SWM_BIT_LIFE]      = (capacitor_life < life_limit_ff) ||
		(fan_life < life_limit_ff);
	assign detect[`SWM_BIT_ENC_HOT]   = enc_overheat;
	assign detect[`SWM_BIT_ENC_COMM]  = enc_over;
	assign detect[`SWM_BIT_REGEN]     = (regen_ratio_pct >= 7'd`SWM_LOAD_PCT);
	assign detect[`SWM_BIT_FAN]       = (fan_count_ff >= FAN_CYCLES);
	assign detect[`SWM_BIT_OVERLOAD]  = (load_ratio_pct >= 7'd`SWM_LOAD_PCT);
	assign detect[`SWM_BIT_EXT_ENC]   = ext_enc_warning;
	assign detect[`SWM_BIT_VIBRATION] = vibration_detected;
	assign detect[`SWM_BIT_EXT_COMM]  = ext_over;

	// ----------------------------------------------------------------
	// latch, mask and clear
	// ----------------------------------------------------------------
	assign set_evt    = detect & ~warning_detect_mask_ff[10:0];
	assign ctrl_clear = wr_en && (paddr == `SWM_OFF_CTRL) && pwdata[`SWM_CTRL_RESET_BIT];
	assign clear_all  = alarm_reset | ctrl_clear;

	always @* begin
		nxt_latched = latched_ff;
		if (clear_all)
			nxt_latched = 11'h000;
		nxt_latched = nxt_latched | set_evt;
	end

	always @* begin
		nxt_irq_status = irq_status_ff;
		// clear only bits already returned; a set since setup survives
		if (rd_en && (paddr == `SWM_OFF_STATUS))
			nxt_irq_status = irq_status_ff & ~prdata[10:0];
		nxt_irq_status = nxt_irq_status | (set_evt & ~latched_ff);
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched_ff    <= 11'h000;
			irq_status_ff <= 11'h000;
		end else begin
			latched_ff    <= nxt_latched;
			irq_status_ff <= nxt_irq_status;
		end
	end

	assign irq = |(irq_status_ff & irq_mask_ff);

	// ----------------------------------------------------------------
	// output routing
	// ----------------------------------------------------------------
	assign unmasked = latched_ff & ~warning_detect_mask_ff[10:0];

	genvar gi;
	generate
		for (gi = 0; gi < 11; gi = gi + 1) begin : g_route
			wire [15:0] code;
			assign code = (gi == `SWM_BIT_OVERLOAD)  ? `SWM_SEL_OVERLOAD :
				(gi == `SWM_BIT_REGEN)     ? `SWM_SEL_REGEN :
				(gi == `SWM_BIT_BATTERY)   ? `SWM_SEL_BATTERY :
				(gi == `SWM_BIT_FAN)       ? `SWM_SEL_FAN :
				(gi == `SWM_BIT_ENC_COMM)  ? `SWM_SEL_ENC_COMM :
				(gi == `SWM_BIT_ENC_HOT)   ? `SWM_SEL_ENC_HOT :
				(gi == `SWM_BIT_VIBRATION) ? `SWM_SEL_VIBRATION :
				(gi == `SWM_BIT_LIFE)      ? `SWM_SEL_LIFE :
				(gi == `SWM_BIT_EXT_ENC)   ? `SWM_SEL_EXT_ENC :
				(gi == `SWM_BIT_EXT_COMM)  ? `SWM_SEL_EXT_COMM : 16'hFFFF;
			assign route_one[gi] = (warning_route_select_one_ff == `SWM_SEL_ALL) ||
				(warning_route_select_one_ff == code);
			assign route_two[gi] = (warning_route_select_two_ff == `SWM_SEL_ALL) ||
				(warning_route_select_two_ff == code);
		end
	endgenerate

	assign warning_output_one = |(unmasked & route_one);
	assign warning_output_two = |(unmasked & route_two);

	// ----------------------------------------------------------------
	// apb registers
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warning_route_select_one_ff <= `SWM_RST_SEL;
			warning_route_select_two_ff <= `SWM_RST_SEL;
			warning_detect_mask_ff      <= `SWM_RST_MASK;
			irq_mask_ff                 <= 11'h000;
			enc_limit_ff                <= `SWM_RST_ENC_LIM;
			ext_limit_ff                <= `SWM_RST_EXT_LIM;
			life_limit_ff               <= `SWM_RST_LIFE_LIM;
		end else if (wr_en) begin
			if (paddr == `SWM_OFF_SEL1)
				warning_route_select_one_ff <= pwdata[15:0];
			else if (paddr == `SWM_OFF_SEL2)
				warning_route_select_two_ff <= pwdata[15:0];
			else if (paddr == `SWM_OFF_MASK)
				warning_detect_mask_ff <= pwdata[15:0];
			else if (paddr == `SWM_OFF_IRQ_MASK)
				irq_mask_ff <= pwdata[10:0];
			else if (paddr == `SWM_OFF_LIMITS) begin
				enc_limit_ff <= pwdata[7:0];
				ext_limit_ff <= pwdata[15:8];
			end else if (paddr == `SWM_OFF_LIFE_LIM)
				life_limit_ff <= pwdata[15:0];
		end
	end

	always @* begin
		nxt_prdata = 32'h00000000;
		if (paddr == `SWM_OFF_SEL1)
			nxt_prdata = {16'h0000, warning_route_select_one_ff};
		else if (paddr == `SWM_OFF_SEL2)
			nxt_prdata = {16'h0000, warning_route_select_two_ff};
		else if (paddr == `SWM_OFF_MASK)
			nxt_prdata = {16'h0000, warning_detect_mask_ff};
		else if (paddr == `SWM_OFF_STATUS)
			nxt_prdata = {5'h00, latched_ff, 5'h00, irq_status_ff};
		else if (paddr == `SWM_OFF_IRQ_MASK)
			nxt_prdata = {21'h000000, irq_mask_ff};
		else if (paddr == `SWM_OFF_LIMITS)
			nxt_prdata = {16'h0000, ext_limit_ff, enc_limit_ff};
		else if (paddr == `SWM_OFF_LIFE_LIM)
			nxt_prdata = {16'h0000, life_limit_ff};
	end

	// read data registered in setup so it is valid in the access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
			prdata <= nxt_prdata;
	end
endmodule // swm_warning_manager

// file: swm_warning_manager_properties.sv
// swm_warning_manager_properties.sv: port-level checker for the warning manager
// assumes: bound to swm_warning_manager, one pclk domain, apb writes on access edge
`timescale 1ns/1ps
`include "swm_defines.vh"
module swm_checker #(
	parameter FAN_CYCLES = 20
) (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [6:0]  load_ratio_pct,
	input wire [6:0]  regen_ratio_pct,
	input wire [15:0] battery_mv,
	input wire        enc_overheat,
	input wire        ext_enc_warning,
	input wire        alarm_reset,
	input wire        warning_output_one,
	input wire        warning_output_two
);
// ----------------------------------------------------------------
// shadow of routing and mask settings
// ----------------------------------------------------------------
	reg  [15:0] sel1_ff;
	reg  [15:0] sel2_ff;
	reg  [15:0] mask_ff;
	wire        wr = psel & penable & pwrite;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel1_ff <= 16'h0000;
			sel2_ff <= 16'h0000;
			mask_ff <= 16'h0000;
		end else if (wr) begin
			if (paddr == `SWM_OFF_SEL1) sel1_ff <= pwdata[15:0];
			if (paddr == `SWM_OFF_SEL2) sel2_ff <= pwdata[15:0];
			if (paddr == `SWM_OFF_MASK) mask_ff <= pwdata[15:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	overload_route_a: assert property (load_ratio_pct >= 7'h55 && !mask_ff[7] && !wr &&
		(sel1_ff == `SWM_SEL_ALL || sel1_ff == `SWM_SEL_OVERLOAD) |=> warning_output_one)
		else $error("overload warning missing on output one");
	regen_route_a: assert property (regen_ratio_pct >= 7'h55 && !mask_ff[5] && !wr &&
		(sel2_ff == `SWM_SEL_ALL || sel2_ff == `SWM_SEL_REGEN) ##1 1'b1 |-> warning_output_two)
		else $error("regeneration warning missing on output two");
	battery_route_a: assert property (battery_mv <= `SWM_BATT_LIM && !mask_ff[0] && !wr &&
		(sel1_ff == `SWM_SEL_ALL || sel1_ff == `SWM_SEL_BATTERY) |=> warning_output_one)
		else $error("battery warning missing on output one");
	enc_hot_route_a: assert property (enc_overheat && !mask_ff[3] && !wr &&
		(sel2_ff == `SWM_SEL_ALL || sel2_ff == `SWM_SEL_ENC_HOT) |=> warning_output_two)
		else $error("encoder overheat warning missing on output two");
	ext_enc_route_a: assert property (ext_enc_warning && !mask_ff[8] && !wr &&
		(sel1_ff == `SWM_SEL_ALL || sel1_ff == `SWM_SEL_EXT_ENC) |=> warning_output_one)
		else $error("external encoder warning missing on output one");
	latch_hold_a: assert property (warning_output_one && !alarm_reset && !wr
		|=> $past(warning_output_one) && warning_output_one) else $error("warning dropped");
	mask_all_a: assert property ((mask_ff | 16'h0002) == 16'h07FF
		|-> !warning_output_one && !warning_output_two) else $error("masked warning shown");
	route_only_a: assert property (sel1_ff == `SWM_SEL_OVERLOAD && mask_ff[7]
		|-> !warning_output_one) else $error("output one shows an unselected type");
endmodule // swm_checker

bind swm_warning_manager swm_checker #(.FAN_CYCLES(FAN_CYCLES)) chk_u (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .load_ratio_pct, .regen_ratio_pct, .battery_mv,
	.enc_overheat, .ext_enc_warning, .alarm_reset, .warning_output_one, .warning_output_two);

// file: swm_host_model.sv
// swm_host_model.sv: host controller sampling both warning outputs each cycle
// assumes: warning outputs are active high levels on pclk
`timescale 1ns/1ps
module swm_host_model (
	input  wire pclk,
	input  wire presetn,
	input  wire warning_output_one,
	input  wire warning_output_two,
	output reg  seen_one_ff,
	output reg  seen_two_ff
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_one_ff <= 1'b0;
			seen_two_ff <= 1'b0;
		end else begin
			seen_one_ff <= warning_output_one;
			seen_two_ff <= warning_output_two;
		end
	end
endmodule // swm_host_model

// file: test_servo_warning_manager.sv
// test_servo_warning_manager.sv: self-checking bench with a cycle model of the latches
// assumes: zero-wait apb slave, FAN_CYCLES shortened to 20
`timescale 1ns/1ps
`include "swm_defines.vh"
module test_servo_warning_manager;
	localparam FAN = 20;
	reg         pclk, presetn, psel, penable, pwrite, fan_stopped, enc_attempt, enc_error;
	reg         enc_overheat, vibration_detected, ext_enc_warning, ext_attempt, ext_error;
	reg         alarm_reset, mdl_on, rerr;
	reg  [11:0] paddr;
	reg  [31:0] pwdata, rd;
	reg  [6:0]  load_ratio_pct, regen_ratio_pct;
	reg  [15:0] battery_mv, capacitor_life, fan_life;
	wire        pready, pslverr, warning_output_one, warning_output_two, irq;
	wire        seen_one_ff, seen_two_ff;
	wire [31:0] prdata;
	integer     err_count, samples_checked, seed, i, j, lat, stk, sel1, sel2, msk, o, d, e;
	int         c2b [0:10];
	swm_warning_manager #(.FAN_CYCLES(FAN)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pready, .prdata, .pslverr, .load_ratio_pct, .regen_ratio_pct,
		.battery_mv, .fan_stopped, .enc_attempt, .enc_error, .enc_overheat, .vibration_detected,
		.capacitor_life, .fan_life, .ext_enc_warning, .ext_attempt, .ext_error, .alarm_reset,
		.warning_output_one, .warning_output_two, .irq);
	swm_host_model host_u (.pclk, .presetn, .warning_output_one, .warning_output_two,
		.seen_one_ff, .seen_two_ff);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
// ----------------------------------------------------------------
// cycle model: latch, sticky status, routing
// ----------------------------------------------------------------
	always @(posedge pclk) begin
		o = lat;
		if (psel && !penable && !pwrite && paddr == `SWM_OFF_STATUS)
			e = lat << 16 | stk;
		d = (load_ratio_pct >= 7'h55) << 7 | (regen_ratio_pct >= 7'h55) << 5 |
			(battery_mv <= 16'h0C80) | enc_overheat << 3 | vibration_detected << 9 |
			(capacitor_life < 16'h0100 || fan_life < 16'h0100) << 2 | ext_enc_warning << 8;
		lat = (alarm_reset || psel && penable && pwrite && paddr == `SWM_OFF_CTRL && pwdata[0])
			? 0 : lat;
		lat = lat | (d & ~msk);
		if (psel && penable && !pwrite && paddr == `SWM_OFF_STATUS)
			stk = stk & ~(e & 32'h7FF);
		stk = stk | (lat & ~o);
		if (psel && penable && pwrite && paddr == `SWM_OFF_SEL1) sel1 = pwdata[15:0];
		if (psel && penable && pwrite && paddr == `SWM_OFF_SEL2) sel2 = pwdata[15:0];
		if (psel && penable && pwrite && paddr == `SWM_OFF_MASK) msk = pwdata[15:0];
		if (!presetn) {lat, stk, sel1, sel2, msk} = 0;
	end
	function bit route(input integer s);
		integer v;
		v = lat & ~msk & 32'h7FF;
		route = s == 0 ? v != 0 : (s <= 10 ? v[c2b[s]] : 1'b0);
	endfunction
	always @(negedge pclk) if (presetn && mdl_on) begin
		chk(warning_output_one, route(sel1));
		chk(warning_output_two, route(sel2));
	end
	task chk(input [31:0] s, input [31:0] x);
		samples_checked = samples_checked + 1;
		if (s !== x) begin
			err_count = err_count + 1;
			$display("mismatch at %0t: saw %h expected %h", $time, s, x);
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] dat);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= dat;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (!pready) @(posedge pclk);
		rd   = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task drive(input r);
		load_ratio_pct     <= r ? 7'h50 + {$random(seed)} % 8 : 7'h00;
		regen_ratio_pct    <= r ? 7'h50 + {$random(seed)} % 8 : 7'h00;
		battery_mv         <= r ? 16'h0C7E + {$random(seed)} % 4 : 16'h0FFF;
		capacitor_life     <= r ? 16'h00FE + {$random(seed)} % 4 : 16'hFFFF;
		fan_life           <= r ? 16'h00FE + {$random(seed)} % 4 : 16'hFFFF;
		fan_stopped        <= r && {$random(seed)} % 2;
		enc_overheat       <= r && {$random(seed)} % 8 == 0;
		vibration_detected <= r && {$random(seed)} % 8 == 0;
		ext_enc_warning    <= r && {$random(seed)} % 8 == 0;
		alarm_reset        <= r && {$random(seed)} % 6 == 0;
	endtask
	task clr;
		@(posedge pclk) alarm_reset <= 1'b1;
		@(posedge pclk) alarm_reset <= 1'b0;
	endtask
	task stat;
		apb(1'b0, `SWM_OFF_STATUS, 0);
		chk(rd, e);
	endtask
	task comm(input x, input integer n, input er);
		repeat (n) begin
			@(posedge pclk);
			{ext_attempt, ext_error} <= x ? {1'b1, er} : 2'b00;
			{enc_attempt, enc_error} <= x ? 2'b00 : {1'b1, er};
			@(posedge pclk);
			{ext_attempt, ext_error, enc_attempt, enc_error} <= 4'h0;
		end
	endtask
	task stop_test;
		$display("checked %0d samples, %0d mismatches", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		err_count = err_count + 1;
		stop_test;
	end
// ----------------------------------------------------------------
// main sequence
// ----------------------------------------------------------------
	initial begin
		err_count = 0;
		samples_checked = 0;
		seed = 32'h5FCF;
		mdl_on = 1'b1;
		c2b = '{7, 7, 5, 0, 6, 4, 3, 9, 2, 8, 10};
		{presetn, psel, penable, pwrite, paddr, pwdata} = 0;
		{enc_attempt, enc_error, ext_attempt, ext_error} = 4'h0;
		drive(1'b0);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 9; i++) begin
			apb(1'b0, i * 4, 0);
			chk(rd, i == 5 ? 32'h0808 : (i == 6 ? 32'h0100 : 32'h0));
			chk(rerr, i == 8);
		end
		for (i = 0; i < 12; i++) begin
			drive(1'b0);
			apb(1'b1, `SWM_OFF_SEL1, i);
			apb(1'b1, `SWM_OFF_SEL2, 11 - i);
			apb(1'b1, `SWM_OFF_MASK, i == 11 ? 32'h7FF : $random(seed) & 32'h7FF | 32'h450);
			repeat (40) @(posedge pclk) drive(1'b1);
		end
		drive(1'b0);
		apb(1'b1, `SWM_OFF_MASK, 0);
		clr;
		apb(1'b1, `SWM_OFF_IRQ_MASK, 32'h100);
		stat;
		@(posedge pclk) ext_enc_warning <= 1'b1;
		@(posedge pclk) ext_enc_warning <= 1'b0;
		repeat (2) @(negedge pclk);
		chk(irq, 1);
		stat;
		@(negedge pclk) chk(irq, 0);
		apb(1'b1, `SWM_OFF_IRQ_MASK, 32'h7F7);
		@(posedge pclk) enc_overheat <= 1'b1;
		@(posedge pclk) enc_overheat <= 1'b0;
		repeat (2) @(negedge pclk);
		chk(irq, 0);
		stat;
		apb(1'b1, `SWM_OFF_CTRL, 32'h1);
		stat;
		mdl_on = 1'b0;
		apb(1'b1, `SWM_OFF_SEL1, `SWM_SEL_FAN);
		clr;
		@(posedge pclk) fan_stopped <= 1'b1;
		repeat (FAN - 1) @(posedge pclk);
		fan_stopped <= 1'b0;
		repeat (2) @(negedge pclk);
		chk(warning_output_one, 0);
		@(posedge pclk) fan_stopped <= 1'b1;
		repeat (FAN + 3) @(posedge pclk);
		@(negedge pclk) chk(warning_output_one, 1);
		chk(seen_one_ff, 1);
		for (j = 0; j < 2; j++) begin
			apb(1'b1, `SWM_OFF_SEL2, j ? `SWM_SEL_EXT_COMM : `SWM_SEL_ENC_COMM);
			clr;
			comm(j, 8, 1'b1);
			comm(j, 1, 1'b0);
			comm(j, 8, 1'b1);
			repeat (4) @(posedge pclk);
			chk(seen_two_ff, 0);
			comm(j, 1, 1'b1);
			repeat (4) @(posedge pclk);
			chk(seen_two_ff, 1);
		end
		stop_test;
	end
endmodule // test_servo_warning_manager
